// File: src/cmas_consts.svh
`ifndef CMAS_CONSTS_SVH
`define CMAS_CONSTS_SVH
// Address line layout (index 13 is the most significant line)
`define CMAS_ADDR_W 14
`define CMAS_STACK_HI 13
`define CMAS_STACK_LO 12
`define CMAS_Y_HI 11
`define CMAS_Y_LO 6
`define CMAS_X_HI 5
`define CMAS_X_LO 0
// Octal digit boundaries inside each coordinate
`define CMAS_XL_HI 2
`define CMAS_XH_LO 3
`define CMAS_YL_HI 8
`define CMAS_YH_LO 9
// Address register value after reset and after the clear pulse
`define CMAS_ADDR_RST 14'h0000
// Interlace word field carried onto the address lines
`define CMAS_IL_HI 23
`define CMAS_IL_LO 10
// Pulse counter values of interest
`define CMAS_T_ACLR 5'h0A
`define CMAS_T_ALOAD 5'h09
`define CMAS_T_MCLR 5'h08
`define CMAS_T_INH_ON 5'h15
`define CMAS_T_INH_OFF 5'h08
`endif

// File: src/cmas_pkg.sv
`default_nettype none
package cmas_pkg;
   typedef logic [13:0] cmas_addr_t;
   typedef logic [23:0] cmas_word_t;
   typedef logic [7:0] cmas_onehot8_t;
   typedef logic [4:0] cmas_pulse_t;
   typedef enum logic [1:0] {CMAS_IDLE, CMAS_READ, CMAS_WRITE} cmas_phase_t;
endpackage
`default_nettype wire

// File: src/cmas_octal_decoder.sv
`default_nettype none
module cmas_octal_decoder (
   input wire logic [2:0] digit,
   output logic [7:0] sel
);
   import cmas_pkg::*;
   // One output per octal value, built per line
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_line
         assign sel[gi] = (digit == 3'(gi));
      end
   endgenerate
endmodule // cmas_octal_decoder
`default_nettype wire

// File: src/cmas_core_memory_address_select.sv
`include "cmas_consts.svh"
`default_nettype none
module cmas_core_memory_address_select #(
   parameter int LINES = 64
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [4:0] pulse_time,
   input wire logic memory_go_set,
   input wire logic memory_go_clear,
   input wire logic cycle_qualifier_one,
   input wire logic cycle_qualifier_two,
   input wire cmas_pkg::cmas_addr_t new_address,
   input wire logic buffer_access,
   input wire logic first_channel_sel,
   input wire cmas_pkg::cmas_word_t first_interlace_address,
   input wire cmas_pkg::cmas_word_t second_interlace_address,
   output cmas_pkg::cmas_addr_t address_reg,
   output cmas_pkg::cmas_addr_t address_lines,
   output logic [3:0] stack_sel,
   output logic [7:0] x_low_sel,
   output logic [7:0] x_high_sel,
   output logic [7:0] y_low_sel,
   output logic [7:0] y_high_sel,
   output logic [63:0] x_line_sel,
   output logic [63:0] y_line_sel,
   output logic [63:0] x_src_a,
   output logic [63:0] x_src_b,
   output logic [63:0] x_sink_a,
   output logic [63:0] x_sink_b,
   output logic [63:0] y_src_a,
   output logic [63:0] y_src_b,
   output logic [63:0] y_sink_a,
   output logic [63:0] y_sink_b,
   output logic memory_go,
   output logic read_dir,
   output logic write_dir,
   output logic inhibit_timing,
   output logic memory_data_clear,
   output logic address_clear
);
   import cmas_pkg::*;

   // Two octal digits per coordinate fix the line count
   if (LINES != 64) begin : g_bad_lines
      $error("only 64 drive lines per coordinate supported");
   end

   cmas_addr_t address_reg_r;
   logic memory_go_r;
   logic inhibit_r;
   logic mdc_r;
   logic aclr_r;
   cmas_addr_t il_addr;

   // Address register: clear at T10, load at T9
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         address_reg_r <= `CMAS_ADDR_RST;
      end else if (clk_en) begin
         if (pulse_time == `CMAS_T_ACLR) begin
            address_reg_r <= `CMAS_ADDR_RST;
         end else if (pulse_time == `CMAS_T_ALOAD) begin
            address_reg_r <= new_address;
         end
      end
   end

   // One-cycle clear strobes registered for the neighbouring registers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         aclr_r <= 1'b0;
         mdc_r <= 1'b0;
      end else if (clk_en) begin
         aclr_r <= (pulse_time == `CMAS_T_ACLR);
         mdc_r <= (pulse_time == `CMAS_T_MCLR);
      end
   end

   // Memory go: set wins over clear so a start is never lost
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         memory_go_r <= 1'b0;
      end else if (clk_en) begin
         if (memory_go_set) begin
            memory_go_r <= 1'b1;
         end else if (memory_go_clear) begin
            memory_go_r <= 1'b0;
         end
      end
   end

   // Inhibit window spans the cycle wrap, T21 on through T8 off
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         inhibit_r <= 1'b0;
      end else if (clk_en) begin
         if (pulse_time == `CMAS_T_INH_ON) begin
            inhibit_r <= 1'b1;
         end else if (pulse_time == `CMAS_T_INH_OFF) begin
            inhibit_r <= 1'b0;
         end
      end
   end

   // Address source mux; decoding stays combinational to avoid a cycle of lag
   assign il_addr = first_channel_sel
      ? first_interlace_address[`CMAS_IL_HI:`CMAS_IL_LO]
      : second_interlace_address[`CMAS_IL_HI:`CMAS_IL_LO];
   assign address_lines = buffer_access ? il_addr : address_reg_r;
   assign address_reg = address_reg_r;

   // Stack select from the two top lines
   always_comb begin
      stack_sel = 4'h0;
      case (address_lines[`CMAS_STACK_HI:`CMAS_STACK_LO])
         2'b00: stack_sel = 4'h1;
         2'b01: stack_sel = 4'h2;
         2'b10: stack_sel = 4'h4;
         2'b11: stack_sel = 4'h8;
         default: stack_sel = 4'h0;
      endcase
   end

   // Four octal digit decoders
   cmas_octal_decoder u_xl (.digit(address_lines[`CMAS_XL_HI:`CMAS_X_LO]), .sel(x_low_sel));
   cmas_octal_decoder u_xh (.digit(address_lines[`CMAS_X_HI:`CMAS_XH_LO]), .sel(x_high_sel));
   cmas_octal_decoder u_yl (.digit(address_lines[`CMAS_YL_HI:`CMAS_Y_LO]), .sel(y_low_sel));
   cmas_octal_decoder u_yh (.digit(address_lines[`CMAS_Y_HI:`CMAS_YH_LO]), .sel(y_high_sel));

   // Direction terms
   assign memory_go = memory_go_r;
   assign inhibit_timing = inhibit_r;
   assign read_dir = memory_go_r && !cycle_qualifier_two;
   assign write_dir = memory_go_r && cycle_qualifier_two
      && (inhibit_r || cycle_qualifier_one);
   assign memory_data_clear = mdc_r;
   assign address_clear = aclr_r;

   // Per-line selection and switch/sink enables; even lines swap ends
   genvar gl;
   generate
      for (gl = 0; gl < LINES; gl = gl + 1) begin : g_line
         localparam bit EVEN = ((gl % 2) == 0);
         assign x_line_sel[gl] = x_high_sel[gl/8] && x_low_sel[gl%8];
         assign y_line_sel[gl] = y_high_sel[gl/8] && y_low_sel[gl%8];
         // Source on end A and sink on end B in one phase, reversed in the other
         assign x_src_a[gl] = x_line_sel[gl] && (EVEN ? write_dir : read_dir);
         assign x_sink_b[gl] = x_src_a[gl];
         assign x_src_b[gl] = x_line_sel[gl] && (EVEN ? read_dir : write_dir);
         assign x_sink_a[gl] = x_src_b[gl];
         assign y_src_a[gl] = y_line_sel[gl] && (EVEN ? write_dir : read_dir);
         assign y_sink_b[gl] = y_src_a[gl];
         assign y_src_b[gl] = y_line_sel[gl] && (EVEN ? read_dir : write_dir);
         assign y_sink_a[gl] = y_src_b[gl];
      end
   endgenerate

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_addr_clear: assert property (clk_en && pulse_time == `CMAS_T_ACLR
      |=> address_reg == 14'h0000) else $error("address not cleared");
   a_addr_load: assert property (clk_en && pulse_time == `CMAS_T_ALOAD
      |=> address_reg == $past(new_address)) else $error("address not loaded");
   a_mdc_pulse: assert property (clk_en && pulse_time == `CMAS_T_MCLR
      |=> memory_data_clear) else $error("data clear missing");
   a_go_set: assert property (clk_en && memory_go_set |=> memory_go)
      else $error("memory go not set");
   a_inh_on: assert property (clk_en && pulse_time == `CMAS_T_INH_ON
      |=> inhibit_timing) else $error("inhibit not raised");
   a_inh_off: assert property (clk_en && pulse_time == `CMAS_T_INH_OFF
      |=> !inhibit_timing) else $error("inhibit not dropped");
   a_dir_excl: assert property (!(read_dir && write_dir))
      else $error("both directions active");
   a_read_term: assert property (memory_go && !cycle_qualifier_two |-> read_dir)
      else $error("read term missing");
   a_line_src: assert property (!buffer_access |-> address_lines == address_reg)
      else $error("line source wrong");
   a_stack_sel: assert property (stack_sel[address_lines[`CMAS_STACK_HI:`CMAS_STACK_LO]])
      else $error("stack mismatch");
   a_one_x: assert property ($onehot(x_line_sel) && $onehot(y_line_sel))
      else $error("line select not one-hot");
   // Each digit decoder must name exactly one line, whatever the source
   a_digit_onehot: assert property ($onehot(x_low_sel) && $onehot(x_high_sel)
      && $onehot(y_low_sel) && $onehot(y_high_sel))
      else $error("decoder not one-hot");
   a_write_term: assert property (memory_go && cycle_qualifier_two
      && (inhibit_timing || cycle_qualifier_one) |-> write_dir) else $error("write term missing");
   a_go_clear: assert property (clk_en && memory_go_clear && !memory_go_set
      |=> !memory_go) else $error("memory go not cleared");
   // A frozen clock enable must leave the address register, memory go and inhibit where they were
   a_freeze_hold: assert property (!clk_en |=> $stable(address_reg)
      && $stable(memory_go) && $stable(inhibit_timing)) else $error("state moved while frozen");
   a_even_swap: assert property (x_line_sel[0] && write_dir
      |-> x_src_a[0] && x_sink_b[0] && !x_src_b[0]) else $error("even line not reversed");
   c_read: cover property (read_dir ##1 !read_dir);
   c_stack_four: cover property (stack_sel[3] && memory_go);
   c_write: cover property (write_dir && inhibit_timing);
   c_buffer: cover property (buffer_access && !first_channel_sel);
endmodule // cmas_core_memory_address_select
`default_nettype wire

// File: tb/cmas_line_model.sv
`default_nettype none
module cmas_line_model (
   input wire logic [63:0] src_a,
   input wire logic [63:0] src_b,
   input wire logic [63:0] sink_a,
   input wire logic [63:0] sink_b,
   output logic fwd,
   output logic rev
);
   timeunit 1ns;
   timeprecision 1ps;
   // Current flows only where a source meets the sink at the far end of its line
   assign fwd = |(src_a & sink_b);
   assign rev = |(src_b & sink_a);
endmodule // cmas_line_model
`default_nettype wire

// File: tb/cmas_core_memory_address_select_tb.sv
`default_nettype none
module cmas_core_memory_address_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cmas_pkg::*;
   logic core_clk, rst_b, clk_en, memory_go_set, memory_go_clear;
   logic cycle_qualifier_one, cycle_qualifier_two, buffer_access, first_channel_sel;
   logic [4:0] pulse_time;
   cmas_addr_t new_address, address_reg, address_lines, e_ar, e;
   cmas_word_t first_interlace_address, second_interlace_address;
   logic [3:0] stack_sel;
   logic [7:0] x_low_sel, x_high_sel, y_low_sel, y_high_sel;
   logic [63:0] x_line_sel, y_line_sel, x_src_a, x_src_b, x_sink_a, x_sink_b;
   logic [63:0] y_src_a, y_src_b, y_sink_a, y_sink_b;
   logic memory_go, read_dir, write_dir, inhibit_timing, memory_data_clear, address_clear;
   logic xf, xr, yf, yr, e_go, e_inh, e_ac, e_mdc, er, ew;
   logic [15:0] lfsr;
   int mismatches, checked;
   localparam logic [4:0] PT [5] = '{5'h0A, 5'h09, 5'h08, 5'h15, 5'h00};
   cmas_core_memory_address_select dut (.core_clk, .rst_b, .clk_en, .pulse_time,
      .memory_go_set, .memory_go_clear, .cycle_qualifier_one, .cycle_qualifier_two,
      .new_address, .buffer_access, .first_channel_sel, .first_interlace_address,
      .second_interlace_address, .address_reg, .address_lines, .stack_sel, .x_low_sel,
      .x_high_sel, .y_low_sel, .y_high_sel, .x_line_sel, .y_line_sel, .x_src_a, .x_src_b,
      .x_sink_a, .x_sink_b, .y_src_a, .y_src_b, .y_sink_a, .y_sink_b, .memory_go, .read_dir,
      .write_dir, .inhibit_timing, .memory_data_clear, .address_clear);
   cmas_line_model xm (.src_a(x_src_a), .src_b(x_src_b), .sink_a(x_sink_a),
      .sink_b(x_sink_b), .fwd(xf), .rev(xr));
   cmas_line_model ym (.src_a(y_src_a), .src_b(y_src_b), .sink_a(y_sink_a),
      .sink_b(y_sink_b), .fwd(yf), .rev(yr));
   // Free running 125 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Sixteen bit shift register gives repeatable stimulus
   task automatic next();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One pulse time; the model mirrors what the flops take on this edge
   task automatic tick(input logic [4:0] p);
      pulse_time = p;
      if (!rst_b) begin
         {e_ar, e_go, e_inh, e_ac, e_mdc} = '0;
      end else if (clk_en) begin
         e_ac = (p == 5'h0A);
         e_mdc = (p == 5'h08);
         if (p == 5'h0A) e_ar = '0;
         if (p == 5'h09) e_ar = new_address;
         if (p == 5'h15) e_inh = 1'b1;
         if (p == 5'h08) e_inh = 1'b0;
         if (memory_go_set) e_go = 1'b1;
         else if (memory_go_clear) e_go = 1'b0;
      end
      @(negedge core_clk);
   endtask
   task automatic chk_all();
      e = buffer_access ? (first_channel_sel ? first_interlace_address[23:10] :
         second_interlace_address[23:10]) : e_ar;
      er = e_go & !cycle_qualifier_two;
      ew = e_go & cycle_qualifier_two & (e_inh | cycle_qualifier_one);
      chk(address_reg, e_ar);
      chk({address_clear, memory_data_clear}, {e_ac, e_mdc});
      chk({memory_go, inhibit_timing}, {e_go, e_inh});
      chk(address_lines, e);
      chk(stack_sel, 4'h1 << e[13:12]);
      chk({y_high_sel, y_low_sel}, {8'h01 << e[11:9], 8'h01 << e[8:6]});
      chk({x_high_sel, x_low_sel}, {8'h01 << e[5:3], 8'h01 << e[2:0]});
      chk(x_line_sel, 64'h1 << e[5:0]);
      chk(y_line_sel, 64'h1 << e[11:6]);
      chk({read_dir, write_dir}, {er, ew});
      chk({xf, xr}, {(er & e[0]) | (ew & !e[0]), (er & !e[0]) | (ew & e[0])});
      chk({yf, yr}, {(er & e[6]) | (ew & !e[6]), (er & !e[6]) | (ew & e[6])});
      chk((x_src_a | x_src_b | x_sink_a | x_sink_b) & ~x_line_sel, 64'h0);
      chk((y_src_a | y_src_b | y_sink_a | y_sink_b) & ~y_line_sel, 64'h0);
   endtask
   task automatic final_report();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Reset, then cycles of random addresses with stalls, a second reset and corners
   initial begin
      {rst_b, memory_go_set, memory_go_clear, cycle_qualifier_one, cycle_qualifier_two} = '0;
      {buffer_access, first_channel_sel, new_address, pulse_time} = '0;
      {first_interlace_address, second_interlace_address, e_ar} = '0;
      {e_go, e_inh, e_ac, e_mdc, mismatches, checked} = '0;
      clk_en = 1'b1;
      lfsr = 16'h845C;
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < 60; i++) begin
         next();
         new_address = (i == 0) ? 14'h061F : (i == 1) ? 14'h3FFF : lfsr[13:0];
         {memory_go_clear, memory_go_set} = lfsr[15:14];
         {cycle_qualifier_two, cycle_qualifier_one} = lfsr[5:4];
         clk_en = (i % 7 != 6);
         rst_b = (i != 20);
         next();
         {buffer_access, first_channel_sel} = (i < 4) ? 2'b00 : lfsr[1:0];
         first_interlace_address = {lfsr, lfsr[15:8]};
         next();
         second_interlace_address = {lfsr[7:0], lfsr};
         foreach (PT[k]) begin
            tick(PT[k]);
            chk_all();
         end
      end
      final_report();
   end
endmodule // cmas_core_memory_address_select_tb
`default_nettype wire
